// >>> design/hwwdt_pkg.sv
// Purpose: constants and carrier types for the hardware watchdog
// Assumes: 32-bit apb, registers at word-aligned byte addresses
// Notes:   offsets 0xA6/0xA7 are indices; byte address is index * 4
package hwwdt_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0]  IDX_SERVICE_KEY    = 8'hA6;
  localparam logic [7:0]  IDX_TIMEOUT_SELECT = 8'hA7;
  localparam logic [11:0] ADDR_SERVICE_KEY   = {2'h0, IDX_SERVICE_KEY, 2'h0};
  localparam logic [11:0] ADDR_TIMEOUT_SELECT = {2'h0, IDX_TIMEOUT_SELECT, 2'h0};
  localparam logic [11:0] ADDR_STATUS        = 12'h2A0;
  // ==========================================================
  // key bytes and fields
  localparam logic [7:0]  KEY_FIRST          = 8'h1E;
  localparam logic [7:0]  KEY_SECOND         = 8'hE1;
  localparam logic [2:0]  SELECT_RESET       = 3'h0;
  localparam int          SELECT_WIDTH       = 3;
  localparam int          COUNT_WIDTH        = 14;
  localparam logic [13:0] COUNT_TERMINAL     = 14'h3FFF;
  localparam int          PRESCALE_WIDTH     = 7;
  // ==========================================================
  // timing
  localparam int          OSC_PER_MACHINE    = 12;
  localparam int          PULSE_OSC_PERIODS  = 96;
  localparam int          CLOCK_NS           = 10;
  localparam int          PULSE_NS           = PULSE_OSC_PERIODS * CLOCK_NS;
  localparam int          PULSE_CYCLES       = PULSE_NS / CLOCK_NS;

  typedef struct packed {
    logic        armed;
    logic        key_half;
    logic [13:0] count;
  } hwwdt_state_t;
endpackage : hwwdt_pkg

// >>> design/hwwdt_top.sv
// Purpose: hardware watchdog with apb slave and reset pulse output
// Assumes: clock is the oscillator; osc_run low models a stopped oscillator
// Notes:   outputs are registered; status register read-only
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
module hwwdt_top #(
  parameter int PRESCALE_W = hwwdt_pkg::PRESCALE_WIDTH
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        osc_run,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             reset_pulse
);
  // ==========================================================
  // reset release synchroniser
  logic rst_meta, rst_n;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // osc_run synchroniser
  logic run_meta, run_sync;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_meta <= 1'b0;
      run_sync <= 1'b0;
    end else begin
      run_meta <= osc_run;
      run_sync <= run_meta;
    end
  end

  // ==========================================================
  // apb decode
  logic access, wr, rd;
  // one take per transfer: the wait-state edge must not apply a write twice
  assign access = psel && penable && !pready;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;
  logic wr_key, wr_sel;
  assign wr_key = wr && (paddr == hwwdt_pkg::ADDR_SERVICE_KEY);
  assign wr_sel = wr && (paddr == hwwdt_pkg::ADDR_TIMEOUT_SELECT);
  logic mapped;
  assign mapped = (paddr == hwwdt_pkg::ADDR_SERVICE_KEY)
               || (paddr == hwwdt_pkg::ADDR_TIMEOUT_SELECT)
               || (paddr == hwwdt_pkg::ADDR_STATUS);

  // ==========================================================
  // watchdog state
  hwwdt_pkg::hwwdt_state_t st, next_st;
  logic [2:0]              sel, next_sel;
  logic [3:0]              osc_div, next_osc_div;
  logic [PRESCALE_W-1:0]   pre, next_pre;
  logic [7:0]              pulse_cnt, next_pulse_cnt;
  logic                    next_reset_pulse;
  logic                    tick, pre_done, overflow, key_ok;
  logic [PRESCALE_W-1:0]   pre_limit;

  // machine cycle and prescale terminal
  always_comb begin
    tick      = run_sync && (osc_div == 4'(hwwdt_pkg::OSC_PER_MACHINE - 1));
    pre_limit = PRESCALE_W'((1 << sel) - 1);
    pre_done  = tick && (pre >= pre_limit);
    overflow  = st.armed && pre_done && (st.count == hwwdt_pkg::COUNT_TERMINAL);
    key_ok    = wr_key && st.key_half && (pwdata[7:0] == hwwdt_pkg::KEY_SECOND);
  end

  // next state
  always_comb begin
    next_st          = st;
    next_sel         = sel;
    next_osc_div     = osc_div;
    next_pre         = pre;
    next_pulse_cnt   = pulse_cnt;
    next_reset_pulse = reset_pulse;
    if (run_sync) begin
      next_osc_div = tick ? 4'h0 : osc_div + 4'h1;
    end
    if (wr_sel) begin
      next_sel = pwdata[2:0];
    end
    // key sequence tracker
    if (wr_key) begin
      next_st.key_half = (pwdata[7:0] == hwwdt_pkg::KEY_FIRST);
    end
    if (st.armed && tick) begin
      next_pre = pre_done ? '0 : pre + 1'b1;
      if (pre_done) begin
        next_st.count = st.count + 14'h0001;
      end
    end
    if (key_ok) begin
      next_st.armed = 1'b1;
      next_st.count = '0;
      next_pre      = '0;
    end
    if (pulse_cnt != 8'h00) begin
      next_pulse_cnt = pulse_cnt - 8'h01;
      if (pulse_cnt == 8'h01) begin
        next_reset_pulse = 1'b0;
      end
    end
    if (overflow) begin
      next_st          = '0;
      next_sel         = hwwdt_pkg::SELECT_RESET;
      next_pre         = '0;
      next_pulse_cnt   = 8'(hwwdt_pkg::PULSE_CYCLES);
      next_reset_pulse = 1'b1;
    end
  end

  // state registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      sel         <= hwwdt_pkg::SELECT_RESET;
      osc_div     <= 4'h0;
      pre         <= '0;
      pulse_cnt   <= 8'h00;
      reset_pulse <= 1'b0;
    end else begin
      st          <= next_st;
      sel         <= next_sel;
      osc_div     <= next_osc_div;
      pre         <= next_pre;
      pulse_cnt   <= next_pulse_cnt;
      reset_pulse <= next_reset_pulse;
    end
  end

  // ==========================================================
  // apb answer
  logic        next_pready, next_pslverr;
  logic [31:0] next_prdata;
  always_comb begin
    next_pready  = access && !pready;
    next_pslverr = access && !pready && !mapped;
    next_prdata  = 32'h0000_0000;
    if (rd && !pready) begin
      case (paddr)
        hwwdt_pkg::ADDR_TIMEOUT_SELECT: next_prdata = {29'h0, sel};
        hwwdt_pkg::ADDR_STATUS:         next_prdata = {30'h0, reset_pulse, st.armed};
        default:                        next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // ==========================================================
  // checks
  property p_idle_after_reset;
    @(posedge clock) $rose(rst_n) |-> !st.armed && st.count == '0;
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset) else $error("armed after reset");

  property p_arm_key;
    @(posedge clock) disable iff (!rst_n) key_ok && !overflow |=> st.armed && st.count == '0;
  endproperty
  a_arm_key: assert property (p_arm_key) else $error("key pair did not arm");

  property p_count_step;
    @(posedge clock) disable iff (!rst_n)
      st.armed && pre_done && !key_ok && !overflow |=> st.count == $past(st.count) + 14'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  property p_no_disarm;
    @(posedge clock) disable iff (!rst_n) st.armed && !overflow |=> st.armed;
  endproperty
  a_no_disarm: assert property (p_no_disarm) else $error("watchdog disarmed");

  property p_restart;
    @(posedge clock) disable iff (!rst_n) st.armed && key_ok |=> st.count == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart failed");

  sequence s_overflow;
    overflow;
  endsequence
  sequence s_pulse_hi;
    reset_pulse [*8];
  endsequence
  property p_overflow_pulse;
    @(posedge clock) disable iff (!rst_n) s_overflow |=> s_pulse_hi ##88 reset_pulse ##1 !reset_pulse;
  endproperty
  a_overflow_pulse: assert property (p_overflow_pulse) else $error("bad reset pulse");

  property p_bad_byte;
    @(posedge clock) disable iff (!rst_n)
      wr_key && pwdata[7:0] != hwwdt_pkg::KEY_FIRST |=> !st.key_half;
  endproperty
  a_bad_byte: assert property (p_bad_byte) else $error("partial key kept");

  property p_hold_stopped;
    @(posedge clock) disable iff (!rst_n) !run_sync && !key_ok |=> $stable(st.count);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("count moved while stopped");

  property p_tick_period;
    @(posedge clock) disable iff (!rst_n) tick |-> osc_div == 4'hB;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("machine cycle wrong");

  // machine ticks never come back to back
  property p_tick_gap;
    @(posedge clock) disable iff (!rst_n) tick |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too close");

  // disarmed counter sits at zero
  property p_disarmed_zero;
    @(posedge clock) disable iff (!rst_n) !st.armed |-> st.count == '0;
  endproperty
  a_disarmed_zero: assert property (p_disarmed_zero) else $error("idle count moved");

  // disarmed prescaler sits at zero
  property p_pre_idle;
    @(posedge clock) disable iff (!rst_n) !st.armed |-> pre == '0;
  endproperty
  a_pre_idle: assert property (p_pre_idle) else $error("idle prescaler moved");

  // overflow returns the timeout select to its reset value
  property p_select_cleared;
    @(posedge clock) disable iff (!rst_n) overflow |=> sel == hwwdt_pkg::SELECT_RESET;
  endproperty
  a_select_cleared: assert property (p_select_cleared) else $error("select kept");

  // pulse pin follows its length counter
  property p_pulse_count;
    @(posedge clock) disable iff (!rst_n) reset_pulse == (pulse_cnt != 8'h00);
  endproperty
  a_pulse_count: assert property (p_pulse_count) else $error("pulse and count differ");

  // ==========================================================
  // apb checks
  // a transfer is taken once
  property p_single_take;
    @(posedge clock) disable iff (!rst_n) access |=> !access;
  endproperty
  a_single_take: assert property (p_single_take) else $error("transfer taken twice");

  // pready lasts one cycle
  property p_ready_pulse;
    @(posedge clock) disable iff (!rst_n) pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");

  // error only alongside ready
  property p_err_with_ready;
    @(posedge clock) disable iff (!rst_n) pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("stray pslverr");

  // read data quiet outside the answer cycle
  property p_prdata_quiet;
    @(posedge clock) disable iff (!rst_n) !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_prdata_quiet: assert property (p_prdata_quiet) else $error("stray read data");

  // key register reads as zero
  property p_key_read_zero;
    @(posedge clock) disable iff (!rst_n)
      rd && paddr == hwwdt_pkg::ADDR_SERVICE_KEY |=> prdata == 32'h0000_0000;
  endproperty
  a_key_read_zero: assert property (p_key_read_zero) else $error("key readable");
endmodule : hwwdt_top

// >>> dv/hwwdt_top_test.sv
// Purpose: self-checking bench for the hardware watchdog
// Assumes: apb answers with one wait state; status bit0 armed, bit1 pulse
// Notes:   full overflow needs 196608 cycles, beyond the run budget
`timescale 1ns/10ps
module hwwdt_top_test;
  // ==========================================================
  // signals
  logic        clock;
  logic        nrst;
  logic        osc_run;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        reset_pulse;
  logic [31:0] rd;
  logic        er;
  logic        pulse_seen = 1'b0;
  logic [7:0]  bad;
  int          error_cnt;
  int          num_checks;

  hwwdt_top dut_u (.clock(clock), .nrst(nrst), .osc_run(osc_run), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .reset_pulse(reset_pulse));

  // ==========================================================
  // clock and pulse monitor
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (reset_pulse === 1'b1) pulse_seen <= 1'b1;

  // ==========================================================
  // tasks
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // one apb transfer, read data and error taken at the edge with pready high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task key_pair(input logic [11:0] a);
    apb(1'b1, a, {24'h0, hwwdt_pkg::KEY_FIRST});
    apb(1'b1, a, {24'h0, hwwdt_pkg::KEY_SECOND});
  endtask : key_pair

  task armed_is(input logic exp);
    apb(1'b0, hwwdt_pkg::ADDR_STATUS, 32'h0);
    check("status", {30'h0, rd[1:0]}, {31'h0, exp});
  endtask : armed_is

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0; osc_run = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; error_cnt = 0; num_checks = 0;
    void'($urandom(32'h067A));
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    check("pulse", {31'h0, reset_pulse}, 32'h0);
    armed_is(1'b0);
    apb(1'b0, hwwdt_pkg::ADDR_SERVICE_KEY, 32'h0);
    check("key_read", rd, 32'h0);
    key_pair(12'hFFC);
    check("unmapped", {31'h0, er}, 32'h1);
    armed_is(1'b0);
    apb(1'b1, hwwdt_pkg::ADDR_SERVICE_KEY, {24'h0, hwwdt_pkg::KEY_SECOND});
    apb(1'b1, hwwdt_pkg::ADDR_SERVICE_KEY, {24'h0, hwwdt_pkg::KEY_FIRST});
    armed_is(1'b0);
    // broken pairs with random stray bytes
    repeat (4) begin
      do bad = 8'($urandom);
      while (bad == hwwdt_pkg::KEY_FIRST || bad == hwwdt_pkg::KEY_SECOND);
      apb(1'b1, hwwdt_pkg::ADDR_SERVICE_KEY, {24'h0, hwwdt_pkg::KEY_FIRST});
      apb(1'b1, hwwdt_pkg::ADDR_SERVICE_KEY, {24'h0, bad});
      apb(1'b1, hwwdt_pkg::ADDR_SERVICE_KEY, {24'h0, hwwdt_pkg::KEY_SECOND});
      armed_is(1'b0);
    end
    // every prescale setting reads back
    for (int i = 7; i >= 0; i--) begin
      apb(1'b1, hwwdt_pkg::ADDR_TIMEOUT_SELECT, {24'h0, 5'($urandom), 3'(i)});
      apb(1'b0, hwwdt_pkg::ADDR_TIMEOUT_SELECT, 32'h0);
      check("select", rd, 32'(i));
    end
    key_pair(hwwdt_pkg::ADDR_SERVICE_KEY);
    armed_is(1'b1);
    apb(1'b1, hwwdt_pkg::ADDR_SERVICE_KEY, 32'h0);
    apb(1'b1, hwwdt_pkg::ADDR_TIMEOUT_SELECT, 32'h0);
    armed_is(1'b1);
    // stopped oscillator holds, then a service restart
    osc_run <= 1'b0;
    repeat (500) @(posedge clock);
    osc_run <= 1'b1;
    key_pair(hwwdt_pkg::ADDR_SERVICE_KEY);
    armed_is(1'b1);
    repeat (20000) @(posedge clock);
    check("early_pulse", {31'h0, pulse_seen}, 32'h0);
    armed_is(1'b1);
    // mid-run reset disarms
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    armed_is(1'b0);
    final_report();
  end
endmodule : hwwdt_top_test
